/* File: verilog/ssp_pkg.sv */
/*
  Package of the serial programming link: word layout, address codes, field positions, reset values.
  Assumes nothing of its surroundings.
*/
package ssp_pkg;

  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned SEL_BITS  = 4;
  localparam int unsigned NUM_WORDS = 8;

  typedef logic [WORD_BITS-1:0] ssp_word_t;
  typedef logic [2:0]           ssp_index_t;

  // Word index selected by the word select field when bit 0 is set.
  localparam logic [2:0] IDX_MAIN_DIV   = 3'h0;
  localparam logic [2:0] IDX_MAIN_REF   = 3'h1;
  localparam logic [2:0] IDX_AUX_DIV    = 3'h2;
  localparam logic [2:0] IDX_MODULATOR  = 3'h4;

  // Field positions.
  localparam int unsigned MAIN_FB_DIV_LSB  = 13;
  localparam int unsigned MAIN_FB_DIV_MSB  = 23;
  localparam int unsigned MAIN_NUM_LSB     = 1;
  localparam int unsigned MAIN_NUM_MSB     = 12;
  localparam int unsigned MAIN_PD_BIT      = 23;
  localparam int unsigned MAIN_PRESC_BIT   = 22;
  localparam int unsigned MAIN_REF_LSB     = 16;
  localparam int unsigned MAIN_REF_MSB     = 21;
  localparam int unsigned MAIN_DEN_LSB     = 4;
  localparam int unsigned MAIN_DEN_MSB     = 15;
  localparam int unsigned AUX_PD_BIT       = 23;
  localparam int unsigned AUTO_PWRUP_BIT   = 23;
  localparam int unsigned MOD_ORDER_LSB    = 14;
  localparam int unsigned MOD_ORDER_MSB    = 15;
  localparam int unsigned DITHER_LSB       = 16;
  localparam int unsigned DITHER_MSB       = 17;

  // Values after reset and start-up word contents.
  localparam ssp_word_t WORD_RESET       = 24'h000000;
  localparam logic [4:0] BIT_COUNT_RESET = 5'h00;
  localparam logic [4:0] BIT_COUNT_FULL  = 5'h18;
  localparam ssp_word_t START_MODULATOR  = 24'h20c709;
  localparam logic [5:0] HOST_DIV_HALF   = 6'h02;
  // Host falling-edge counts at which the strobe drops and the frame ends; the gap lets the
  // device's strobe synchroniser follow both edges of the strobe before the next word.
  localparam logic [4:0] HOST_STROBE_DROP = 5'h1a;
  localparam logic [4:0] HOST_LATCH_DONE  = 5'h1c;

endpackage

/* File: verilog/ssp_link_if.sv */
/*
  Three-wire programming link between host controller and synthesizer.
  Assumes the host drives all three wires and the device only listens.
*/
`timescale 1ns/1ps
interface ssp_link_if;
  logic link_clk;
  logic link_data;
  logic latch_strobe;

  modport host (output link_clk, output link_data, output latch_strobe);
  modport dev  (input  link_clk, input  link_data, input  latch_strobe);
endinterface

/* File: verilog/ssp_sync2.sv */
/*
  Two flip-flop level synchroniser.
  Assumes the input is a level from another clock domain.
*/
`timescale 1ns/1ps
module ssp_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } ssp_sync_s;

  ssp_sync_s state_reg;
  ssp_sync_s state_next;

  always_comb begin
    state_next.meta = d_i;
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q_o = state_reg.sync;
endmodule // ssp_sync2

/* File: verilog/ssp_device.sv */
/*
  Device end: serial shift register, word decode, control words and power state.
  Assumes the host keeps the link rules; the link clock is the only clock here.
*/
`timescale 1ns/1ps
module ssp_device (
  ssp_link_if.dev              link,
  input  wire logic            rst_n_i,
  input  wire logic            chip_enable_i,
  output logic                 main_powered_o,
  output logic                 aux_powered_o,
  output logic                 counter_reset_o,
  output logic [10:0]          main_feedback_divider_o,
  output logic [11:0]          main_frac_numerator_o,
  output logic [11:0]          main_frac_denominator_o,
  output logic                 main_prescaler_select_o,
  output logic [5:0]           main_reference_divider_o,
  output logic [1:0]           modulator_order_o,
  output logic [1:0]           dither_level_o,
  output ssp_pkg::ssp_word_t   word_o [ssp_pkg::NUM_WORDS]
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ssp_pkg::ssp_word_t                        shift;
    logic [4:0]                                count;
    logic                                      strobe_d;
    logic [ssp_pkg::NUM_WORDS-1:0][ssp_pkg::WORD_BITS-1:0] words;
    logic                                      main_autoup;
    logic                                      aux_autoup;
    logic                                      cnt_rst;
  } ssp_dev_s;

  ssp_dev_s state_reg;
  ssp_dev_s state_next;
  logic     strobe_s;
  logic     data_s;
  logic     strobe_rise;
  logic [2:0] sel;

  // Strobe and data are launched by the host on its clock; resync the strobe, data is taken directly.
  ssp_sync2 u_sync_strobe (
    .clk_i   (link.link_clk),
    .rst_n_i (rst_n_i),
    .d_i     (link.latch_strobe),
    .q_o     (strobe_s)
  );

  assign data_s      = link.link_data;
  assign strobe_rise = strobe_s && !state_reg.strobe_d;
  // Bit 0 clear always means word 0, whatever bits 3..1 hold.
  assign sel = state_reg.shift[0] ? state_reg.shift[3:1] : ssp_pkg::IDX_MAIN_DIV;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next          = state_reg;
    state_next.strobe_d = strobe_s;
    state_next.cnt_rst  = 1'b0;
    // Shifting stops after 24 bits, so the edges that carry the strobe through the synchroniser
    // cannot push bits out of a complete word.
    if (!strobe_s && state_reg.count != ssp_pkg::BIT_COUNT_FULL) begin
      state_next.shift = {state_reg.shift[ssp_pkg::WORD_BITS-2:0], data_s};
      state_next.count = 5'(state_reg.count + 5'h01);
    end
    if (strobe_rise) begin
      state_next.count = ssp_pkg::BIT_COUNT_RESET;
      // A short word commits nothing.
      if (state_reg.count == ssp_pkg::BIT_COUNT_FULL) begin
        state_next.words[sel] = state_reg.shift;
        if (sel == ssp_pkg::IDX_MAIN_DIV) begin
          state_next.cnt_rst     = 1'b1;
          state_next.main_autoup = state_reg.words[ssp_pkg::IDX_MODULATOR][ssp_pkg::AUTO_PWRUP_BIT];
        end
        if (sel == ssp_pkg::IDX_AUX_DIV) begin
          state_next.aux_autoup = state_reg.words[ssp_pkg::IDX_MODULATOR][ssp_pkg::AUTO_PWRUP_BIT];
        end
        // A fresh word 1 write cancels an earlier main auto power-up.
        if (sel == ssp_pkg::IDX_MAIN_REF) begin
          state_next.main_autoup = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (!rst_n_i) begin
      state_reg       <= '0;
      state_reg.words <= '0;
      state_reg.words[ssp_pkg::IDX_MODULATOR] <= ssp_pkg::START_MODULATOR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Chip enable acts without the clock and overrides the power-down and auto power-up bits.
  always_comb begin
    main_powered_o = chip_enable_i && (state_reg.main_autoup ||
      !state_reg.words[ssp_pkg::IDX_MAIN_REF][ssp_pkg::MAIN_PD_BIT]);
    aux_powered_o  = chip_enable_i && (state_reg.aux_autoup ||
      !state_reg.words[ssp_pkg::IDX_AUX_DIV][ssp_pkg::AUX_PD_BIT]);
  end

  assign counter_reset_o          = state_reg.cnt_rst;
  assign main_feedback_divider_o  = state_reg.words[0][ssp_pkg::MAIN_FB_DIV_MSB:ssp_pkg::MAIN_FB_DIV_LSB];
  assign main_frac_numerator_o    = state_reg.words[0][ssp_pkg::MAIN_NUM_MSB:ssp_pkg::MAIN_NUM_LSB];
  assign main_frac_denominator_o  = state_reg.words[1][ssp_pkg::MAIN_DEN_MSB:ssp_pkg::MAIN_DEN_LSB];
  assign main_prescaler_select_o  = state_reg.words[1][ssp_pkg::MAIN_PRESC_BIT];
  assign main_reference_divider_o = state_reg.words[1][ssp_pkg::MAIN_REF_MSB:ssp_pkg::MAIN_REF_LSB];
  assign modulator_order_o        = state_reg.words[4][ssp_pkg::MOD_ORDER_MSB:ssp_pkg::MOD_ORDER_LSB];
  assign dither_level_o           = state_reg.words[4][ssp_pkg::DITHER_MSB:ssp_pkg::DITHER_LSB];

  for (genvar i = 0; i < ssp_pkg::NUM_WORDS; i++) begin : g_words
    assign word_o[i] = state_reg.words[i];
  end
endmodule // ssp_device

/* File: verilog/ssp_host.sv */
/*
  Host end: takes 24-bit words over a plain register port and shifts them out on the link.
  Assumes software writes one word at a time and polls the busy bit.
*/
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module ssp_host (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  ssp_link_if.host         link
);
  // Register 0 write: word to send; read: last word. Register 1 read: busy.
  localparam logic [1:0] ADDR_WORD   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_LATCH = 2'b11
  } ssp_host_state_e;

  typedef struct packed {
    ssp_host_state_e    st;
    ssp_pkg::ssp_word_t word;
    ssp_pkg::ssp_word_t shift;
    logic [4:0]         bits;
    logic [5:0]         div;
    logic               sclk;
    logic               strobe;
    logic [31:0]        rdata;
  } ssp_host_s;

  ssp_host_s state_reg;
  ssp_host_s state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.rdata = 32'h00000000;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_WORD:   state_next.rdata = {8'h00, state_reg.word};
        ADDR_STATUS: state_next.rdata = {31'h00000000, state_reg.st != ST_IDLE};
        default:     state_next.rdata = 32'h00000000;
      endcase
    end
    state_next.div = 6'(state_reg.div + 6'h01);
    unique case (state_reg.st)
      ST_IDLE: begin
        state_next.div = ssp_pkg::HOST_DIV_HALF - 6'h01;
        if (wr_i && addr_i == ADDR_WORD) begin
          state_next.word  = wdata_i[ssp_pkg::WORD_BITS-1:0];
          state_next.shift = wdata_i[ssp_pkg::WORD_BITS-1:0];
          state_next.bits  = ssp_pkg::BIT_COUNT_RESET;
          state_next.st    = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (state_reg.div == ssp_pkg::HOST_DIV_HALF - 6'h01) begin
          state_next.div  = 6'h00;
          state_next.sclk = !state_reg.sclk;
          // Data changes on the falling edge; the device samples on the rising one.
          if (state_reg.sclk) begin
            state_next.shift = {state_reg.shift[ssp_pkg::WORD_BITS-2:0], 1'b0};
            state_next.bits  = 5'(state_reg.bits + 5'h01);
            if (state_reg.bits == ssp_pkg::BIT_COUNT_FULL - 5'h01) begin
              state_next.st     = ST_LATCH;
              state_next.strobe = 1'b1;
            end
          end
        end
      end
      ST_LATCH: begin
        // The strobe only moves with a falling link edge, never beside a rising one, and the
        // clock runs on after it drops so that the device sees the strobe fall before the next word.
        if (state_reg.div == ssp_pkg::HOST_DIV_HALF - 6'h01) begin
          state_next.div  = 6'h00;
          state_next.sclk = !state_reg.sclk;
          if (state_reg.sclk) begin
            state_next.bits = 5'(state_reg.bits + 5'h01);
            if (state_reg.bits == ssp_pkg::HOST_STROBE_DROP) begin
              state_next.strobe = 1'b0;
            end
            if (state_reg.bits == ssp_pkg::HOST_LATCH_DONE) begin
              state_next.st = ST_IDLE;
            end
          end
        end
      end
      default: state_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o           = state_reg.rdata;
  assign link.link_clk     = state_reg.sclk;
  assign link.link_data    = state_reg.shift[ssp_pkg::WORD_BITS-1];
  assign link.latch_strobe = state_reg.strobe;
endmodule // ssp_host

/* File: verif/ssp_link_properties.sv */
/*
  Checker of the three-wire link and the device's power and load outputs.
  Assumes the bench instantiates it beside the link interface and feeds it both resets.
*/
`timescale 1ns/1ps
module ssp_link_properties (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        dev_rst_n_i,
  input  wire logic        link_clk,
  input  wire logic        link_data,
  input  wire logic        latch_strobe,
  input  wire logic        chip_enable_i,
  input  wire logic        main_powered_o,
  input  wire logic        aux_powered_o,
  input  wire logic        counter_reset_o,
  input  wire logic [10:0] main_feedback_divider_o
);
  logic [4:0]  rise_cnt_reg;
  logic [2:0]  still_reg;
  logic        clk_prev_reg;
  logic [23:0] shift_reg;
  logic [23:0] held_reg;

  // Rising link clock edges of the current frame, seen from the host clock; a rising edge after
  // the link clock stood still opens a new frame.
  always_ff @(posedge clk_i) begin
    clk_prev_reg <= link_clk;
    if (!rst_n_i || link_clk != clk_prev_reg) begin
      still_reg <= 3'h0;
    end else if (still_reg != 3'h7) begin
      still_reg <= still_reg + 3'h1;
    end
    if (!rst_n_i || latch_strobe) begin
      rise_cnt_reg <= 5'h00;
    end else if (link_clk && !clk_prev_reg) begin
      if (still_reg >= 3'h4) begin
        rise_cnt_reg <= 5'h01;
      end else if (rise_cnt_reg != 5'h1f) begin
        rise_cnt_reg <= rise_cnt_reg + 5'h01;
      end
    end
  end

  // Shadow of the device's shift register; the word is held while the strobe is high.
  always_ff @(posedge link_clk) begin
    if (!latch_strobe) begin
      shift_reg <= {shift_reg[22:0], link_data};
    end else begin
      held_reg <= shift_reg;
    end
  end

  sequence s_commit;
    $rose(counter_reset_o);
  endsequence

  a_word_after_24: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(latch_strobe) |-> rise_cnt_reg == 5'h18) else $error("strobe raised without 24 bits");
  a_strobe_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(latch_strobe) |-> latch_strobe [*3]) else $error("strobe pulse too short");
  a_data_at_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(link_clk) |-> $stable(link_data)) else $error("data moved on rising link clock");
  a_ce_powerdown: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !chip_enable_i |-> !main_powered_o && !aux_powered_o) else $error("powered with enable low");
  a_pulse_single: assert property (@(posedge link_clk) disable iff (!dev_rst_n_i)
    s_commit |=> !counter_reset_o) else $error("counter reset longer than one cycle");
  a_reset_word0: assert property (@(posedge link_clk) disable iff (!dev_rst_n_i)
    s_commit |-> !held_reg[0]) else $error("counter reset without word 0 load");
  a_divider_loaded: assert property (@(posedge link_clk) disable iff (!dev_rst_n_i)
    s_commit |-> ##[0:1] main_feedback_divider_o == held_reg[23:13]) else $error("divider field wrong");
  a_word_hold: assert property (@(posedge link_clk) disable iff (!dev_rst_n_i)
    !$stable(main_feedback_divider_o) |-> $past(latch_strobe) || $past(latch_strobe, 2)
    || $past(latch_strobe, 3) || $past(latch_strobe, 4)) else $error("divider changed without strobe");
endmodule // ssp_link_properties

/* File: verif/tb.sv */
/*
  Self-checking bench: host and device joined by the link, software port driven by tasks.
  Assumes the host answers reads one cycle later and reports busy in register 1 bit 0.
*/
`timescale 1ns/1ps
module tb;
  logic               clk_i, rst_n_i, dev_rst_n, wr_i, rd_i, ce;
  logic [1:0]         addr_i, mod_ord, dither_level;
  logic [31:0]        wdata_i, rdata_o, rd_val;
  logic               main_pw, aux_pw, ctr_rst, presc;
  logic [10:0]        fb_div;
  logic [11:0]        num, den;
  logic [5:0]         ref_div;
  ssp_pkg::ssp_word_t words [ssp_pkg::NUM_WORDS];
  ssp_pkg::ssp_word_t exp_w [ssp_pkg::NUM_WORDS];
  int                 n_errors, n_tests, cycles;

  ssp_link_if link_if ();
  ssp_host ssp_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link_if.host));
  ssp_device ssp_device_inst (.link(link_if.dev), .rst_n_i(dev_rst_n), .chip_enable_i(ce),
    .main_powered_o(main_pw), .aux_powered_o(aux_pw), .counter_reset_o(ctr_rst),
    .main_feedback_divider_o(fb_div), .main_frac_numerator_o(num), .main_frac_denominator_o(den),
    .main_prescaler_select_o(presc), .main_reference_divider_o(ref_div), .modulator_order_o(mod_ord),
    .dither_level_o(dither_level), .word_o(words));
  ssp_link_properties ssp_link_properties_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_rst_n_i(dev_rst_n),
    .link_clk(link_if.link_clk), .link_data(link_if.link_data), .latch_strobe(link_if.latch_strobe),
    .chip_enable_i(ce), .main_powered_o(main_pw), .aux_powered_o(aux_pw), .counter_reset_o(ctr_rst),
    .main_feedback_divider_o(fb_div));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Sends one word and waits, bounded, for the host to go idle.
  task automatic send(input ssp_pkg::ssp_word_t w);
    int k;
    wr(2'h0, {8'h00, w});
    k = 0;
    rd_val = 32'h1;
    while (rd_val[0] !== 1'b0 && k < 300) begin
      rd(2'h1, rd_val);
      k++;
    end
    check("busy", 32'h0, {31'h0, rd_val[0]});
    repeat (8) @(posedge clk_i);
  endtask

  task automatic pw(input logic m, input logic a);
    @(posedge clk_i);
    check("main_powered", {31'h0, m}, {31'h0, main_pw});
    check("aux_powered", {31'h0, a}, {31'h0, aux_pw});
  endtask

  task automatic t_reset();
    rd(2'h2, rd_val);
    check("unmapped", 32'h0, rd_val);
    check("word1", 32'h0, {8'h0, words[1]});
    check("word4", {8'h0, ssp_pkg::START_MODULATOR}, {8'h0, words[4]});
    check("mod_order", 32'h3, 32'(mod_ord));
    check("dither", 32'h0, 32'(dither_level));
  endtask

  task automatic t_words();
    ssp_pkg::ssp_word_t w0;
    w0 = 24'h5a3c9e;
    for (int i = 1; i < 8; i++) begin
      exp_w[i] = {4'h3, 4'(i), 12'ha5c, 3'(i), 1'b1};
      send(exp_w[i]);
    end
    send(w0);
    for (int i = 1; i < 8; i++) check("word", {8'h0, exp_w[i]}, {8'h0, words[i]});
    check("fb_div", 32'(w0[23:13]), 32'(fb_div));
    check("numerator", 32'(w0[12:1]), 32'(num));
    check("denominator", 32'(exp_w[1][15:4]), 32'(den));
    check("ref_div", 32'(exp_w[1][21:16]), 32'(ref_div));
    check("prescaler", 32'(exp_w[1][22]), 32'(presc));
  endtask

  task automatic t_power();
    pw(1'b1, 1'b1);
    send(exp_w[1] | 24'h800000);
    pw(1'b0, 1'b1);
    send(exp_w[2] | 24'h800000);
    pw(1'b0, 1'b0);
    send(exp_w[2]);
    send(exp_w[4] | 24'h800000);
    send(24'h5a3c9e);
    pw(1'b1, 1'b1);
    send(exp_w[2] | 24'h800000);
    pw(1'b1, 1'b1);
    ce <= 1'b0;
    pw(1'b0, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_n_i, dev_rst_n, wr_i, rd_i, addr_i, wdata_i, ce} = {38'h0, 1'b1};
    {n_errors, n_tests, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // The device only resets on link clock edges, so a word is shifted while it is held.
    send(24'h000003);
    dev_rst_n <= 1'b1;
    t_reset();
    t_words();
    t_power();
    tally_and_finish();
  end
endmodule // tb
